// >>> ipsr_pkg.sv
// Package of offsets, field positions, reset values and types for the priority and status registers.
package ipsr_pkg;

   // ==========================================================================
   // Register byte addresses
   // ==========================================================================
   localparam logic [4:0] IPSR_SERIAL3_OFF   = 5'h00;
   localparam logic [4:0] IPSR_S4USB_OFF     = 5'h04;
   localparam logic [4:0] IPSR_SPI3S4_OFF    = 5'h08;
   localparam logic [4:0] IPSR_CAPCMP9_OFF   = 5'h0C;
   localparam logic [4:0] IPSR_CTRLSTAT_OFF  = 5'h10;
   localparam logic [4:0] IPSR_IRQ_STAT_OFF  = 5'h14;
   localparam logic [4:0] IPSR_IRQ_MASK_OFF  = 5'h18;

   // ==========================================================================
   // Sources and field layout
   // ==========================================================================
   localparam int         IPSR_NSRC          = 13;
   localparam int         IPSR_NPRIO_REGS    = 4;
   localparam logic [2:0] IPSR_PRIO_RESET    = 3'h4;
   localparam logic [2:0] IPSR_PRIO_OFF      = 3'h0;
   localparam logic [15:0] IPSR_REG_MASK [IPSR_NPRIO_REGS] = '{16'h7770, 16'h7777, 16'h7777, 16'h0077};

   // Control and status field positions.
   localparam int         IPSR_UNACKED_BIT   = 15;
   localparam int         IPSR_CAPSEL_BIT    = 13;
   localparam int         IPSR_LEVEL_LSB     = 8;
   localparam logic [3:0] IPSR_LEVEL_RESET   = 4'h0;
   localparam logic [6:0] IPSR_VECTOR_RESET  = 7'h00;
   localparam logic [7:0] IPSR_VECTOR_BASE   = 8'h08;

   // Event status bits: 0 request raised, 1 request acknowledged.
   localparam int         IPSR_NEVT          = 2;

   // AXI4-Lite responses.
   localparam logic [1:0] IPSR_RESP_OKAY     = 2'h0;
   localparam logic [1:0] IPSR_RESP_SLVERR   = 2'h2;

   typedef logic [2:0] ipsr_prio_t;

endpackage

// >>> ipsr_top.sv
// Priority registers, control and status register and request arbiter of the interrupt controller.
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - each 3-bit field sets its source's level 1 to 7 equal to its value.
// - a field of zero disables its source; it never raises a request.
// - reset loads every priority field with 100 and the status register with zero.
// - unimplemented bits read zero and ignore writes.
// - first register holds serial3 tx 14:12, rx 10:8, error 6:4.
// - second holds serial4 error, usb, i2c3 master, i2c3 slave fields.
// - third holds spi3 event, spi3 fault, serial4 tx, serial4 rx fields.
// - fourth holds capture9 in 6:4 and compare9 in 2:0; 15:7 unused.
// - bit 15 reads one while the highest live request is held off at or below the CPU level and not forwarded.
// - capture-select one makes the vector field show the highest pending request.
// - capture-select zero makes the vector field show the last acknowledged request.
// - bits 11:8 show the new CPU priority level, 0 to 7.
// - bits 6:0 hold vector number minus eight, vectors 8 to 135.
module ipsr_top (
   input  wire logic                       clk_in,
   input  wire logic                       rst_n_in,
   input  wire logic [31:0]                s_axi_awaddr_in,
   input  wire logic                       s_axi_awvalid_in,
   output logic                            s_axi_awready_out,
   input  wire logic [31:0]                s_axi_wdata_in,
   input  wire logic [3:0]                 s_axi_wstrb_in,
   input  wire logic                       s_axi_wvalid_in,
   output logic                            s_axi_wready_out,
   output logic [1:0]                      s_axi_bresp_out,
   output logic                            s_axi_bvalid_out,
   input  wire logic                       s_axi_bready_in,
   input  wire logic [31:0]                s_axi_araddr_in,
   input  wire logic                       s_axi_arvalid_in,
   output logic                            s_axi_arready_out,
   output logic [31:0]                     s_axi_rdata_out,
   output logic [1:0]                      s_axi_rresp_out,
   output logic                            s_axi_rvalid_out,
   input  wire logic                       s_axi_rready_in,
   input  wire logic [ipsr_pkg::IPSR_NSRC-1:0] src_flag_in,
   input  wire logic [ipsr_pkg::IPSR_NSRC-1:0] src_enable_in,
   input  wire logic [6:0]                 src_vector_code_in [ipsr_pkg::IPSR_NSRC],
   input  wire logic [3:0]                 cpu_level_in,
   input  wire logic                       cpu_ack_in,
   output logic                            cpu_request_out,
   output logic [6:0]                      cpu_vector_code_out,
   output logic [3:0]                      cpu_new_level_out,
   output logic                            irq_out
);
   import ipsr_pkg::*;

   // ==========================================================================
   // Register storage
   // ==========================================================================
   logic [15:0]          prio_reg [IPSR_NPRIO_REGS];
   logic                 vector_capture_select;
   logic                 unacked_request;
   logic [3:0]           new_cpu_level;
   logic [6:0]           acked_vector;
   logic [IPSR_NEVT-1:0] irq_stat;
   logic [IPSR_NEVT-1:0] irq_mask;

   // ==========================================================================
   // AXI4-Lite write channel
   // ==========================================================================
   logic        aw_held;
   logic        w_held;
   logic [4:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;

   wire        aw_take   = s_axi_awvalid_in & s_axi_awready_out;
   wire        w_take    = s_axi_wvalid_in & s_axi_wready_out;
   wire        wr_fire   = aw_held & w_held & ~s_axi_bvalid_out;
   wire [4:0]  wr_addr   = aw_addr;
   wire        wr_lo     = w_strb[0];
   wire        wr_hi     = w_strb[1];
   wire        wr_known  = (wr_addr <= IPSR_IRQ_MASK_OFF) && (wr_addr[1:0] == 2'h0);
   wire [15:0] wr_word   = w_data[15:0];

   // Address and data are parked in holding registers as they arrive, in either order.
   // The response goes out once both are held, and neither ready rises again
   // until it has been taken, so one write at most is in flight.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         aw_held           <= 1'b0;
         w_held            <= 1'b0;
         aw_addr           <= 5'h00;
         w_data            <= 32'h00000000;
         w_strb            <= 4'h0;
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out  <= 1'b0;
         s_axi_bvalid_out  <= 1'b0;
         s_axi_bresp_out   <= IPSR_RESP_OKAY;
      end else begin
         s_axi_awready_out <= ~aw_held & ~aw_take & ~s_axi_bvalid_out & ~wr_fire;
         s_axi_wready_out  <= ~w_held & ~w_take & ~s_axi_bvalid_out & ~wr_fire;
         if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_in[4:0];
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
         if (w_take) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata_in;
            w_strb <= s_axi_wstrb_in;
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
         if (wr_fire) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= wr_known ? IPSR_RESP_OKAY : IPSR_RESP_SLVERR;
         end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // Priority registers
   // ==========================================================================
   ipsr_prio_t src_prio [IPSR_NSRC];

   // Field unpacking for the four registers in source order.
   assign src_prio[0]  = prio_reg[0][14:12];
   assign src_prio[1]  = prio_reg[0][10:8];
   assign src_prio[2]  = prio_reg[0][6:4];
   assign src_prio[3]  = prio_reg[1][14:12];
   assign src_prio[4]  = prio_reg[1][10:8];
   assign src_prio[5]  = prio_reg[1][6:4];
   assign src_prio[6]  = prio_reg[1][2:0];
   assign src_prio[7]  = prio_reg[2][14:12];
   assign src_prio[8]  = prio_reg[2][10:8];
   assign src_prio[9]  = prio_reg[2][6:4];
   assign src_prio[10] = prio_reg[2][2:0];
   assign src_prio[11] = prio_reg[3][6:4];
   assign src_prio[12] = prio_reg[3][2:0];

   // Unimplemented bits are masked on every write, so they always read zero.
   genvar gi;
   generate
      for (gi = 0; gi < IPSR_NPRIO_REGS; gi++) begin : g_prio
         localparam logic [4:0] OFF = 5'(gi * 4);
         localparam logic [15:0] RST_VAL = IPSR_REG_MASK[gi] & {4{1'b0, IPSR_PRIO_RESET}};
         wire        hit     = wr_fire & (wr_addr == OFF);
         wire [15:0] lane    = {wr_hi ? wr_word[15:8] : prio_reg[gi][15:8],
                                wr_lo ? wr_word[7:0]  : prio_reg[gi][7:0]};
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               prio_reg[gi] <= RST_VAL;
            end else if (hit) begin
               prio_reg[gi] <= lane & IPSR_REG_MASK[gi];
            end
         end
      end
   endgenerate

   // ==========================================================================
   // Arbiter: highest level wins, lowest index breaks ties
   // ==========================================================================
   logic [IPSR_NSRC-1:0] src_live;
   ipsr_prio_t           best_prio;
   logic [6:0]           best_vector;
   logic                 best_valid;
   ipsr_prio_t           fwd_prio;

   generate
      for (gi = 0; gi < IPSR_NSRC; gi++) begin : g_live
         assign src_live[gi] = src_flag_in[gi] & src_enable_in[gi] & (src_prio[gi] != IPSR_PRIO_OFF);
      end
   endgenerate

   // The walk runs from the top index down with a greater-or-equal compare,
   // so on equal levels the lowest index ends up chosen.
   always_comb begin
      best_prio   = IPSR_PRIO_OFF;
      best_vector = IPSR_VECTOR_RESET;
      best_valid  = 1'b0;
      for (int i = IPSR_NSRC - 1; i >= 0; i--) begin
         if (src_live[i] && (src_prio[i] >= best_prio)) begin
            best_prio   = src_prio[i];
            best_vector = src_vector_code_in[i];
            best_valid  = 1'b1;
         end
      end
   end

   wire        beats_cpu   = best_valid & ({1'b0, best_prio} > cpu_level_in);
   wire        held_off    = best_valid & ~beats_cpu;
   // An acknowledge counts only while a request stands; a stray pulse is ignored.
   // The request then drops for one cycle before it may rise again.
   wire        take_ack    = cpu_ack_in & cpu_request_out;
   wire [6:0]  shown_vec   = vector_capture_select ? best_vector : acked_vector;

   // ==========================================================================
   // CPU side and status state
   // ==========================================================================
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cpu_request_out     <= 1'b0;
         cpu_vector_code_out <= IPSR_VECTOR_RESET;
         fwd_prio            <= IPSR_PRIO_OFF;
         cpu_new_level_out   <= IPSR_LEVEL_RESET;
         unacked_request     <= 1'b0;
         new_cpu_level       <= IPSR_LEVEL_RESET;
         acked_vector        <= IPSR_VECTOR_RESET;
      end else begin
         cpu_request_out     <= beats_cpu & ~take_ack;
         // The level is registered beside the vector, so an acknowledge
         // captures both from the same source.
         cpu_vector_code_out <= best_vector;
         fwd_prio            <= best_prio;
         unacked_request     <= held_off;
         if (take_ack) begin
            acked_vector      <= cpu_vector_code_out;
            new_cpu_level     <= {1'b0, fwd_prio};
            cpu_new_level_out <= {1'b0, fwd_prio};
         end
      end
   end

   // ==========================================================================
   // Control bit, event status and mask
   // ==========================================================================
   wire                 ctl_hit  = wr_fire & wr_lo & (wr_addr == IPSR_CTRLSTAT_OFF);
   wire                 ctl_hi   = wr_fire & wr_hi & (wr_addr == IPSR_CTRLSTAT_OFF);
   wire                 stat_hit = wr_fire & wr_lo & (wr_addr == IPSR_IRQ_STAT_OFF);
   wire                 mask_hit = wr_fire & wr_lo & (wr_addr == IPSR_IRQ_MASK_OFF);
   wire [IPSR_NEVT-1:0] evt_set  = {take_ack, beats_cpu & ~cpu_request_out};
   wire [IPSR_NEVT-1:0] evt_clr  = stat_hit ? wr_word[IPSR_NEVT-1:0] : '0;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         vector_capture_select <= 1'b0;
         irq_stat              <= '0;
         irq_mask              <= '0;
         irq_out               <= 1'b0;
      end else begin
         if (ctl_hi) begin
            vector_capture_select <= wr_word[IPSR_CAPSEL_BIT];
         end
         if (mask_hit) begin
            irq_mask <= wr_word[IPSR_NEVT-1:0];
         end
         // A new event wins over a clear in the same cycle, so none is lost.
         // The output follows the next state, so it moves with the status bits.
         irq_stat <= (irq_stat & ~evt_clr) | evt_set;
         irq_out  <= |(((irq_stat & ~evt_clr) | evt_set) & (mask_hit ? wr_word[IPSR_NEVT-1:0] : irq_mask));
      end
   end

   // ==========================================================================
   // AXI4-Lite read channel
   // ==========================================================================
   // A read answers one cycle after its address is taken.
   // Registers sit in the low half of the word; the upper half, unmapped
   // addresses and the gaps of the control word read as zero.
   wire [4:0]  rd_addr  = s_axi_araddr_in[4:0];
   wire        rd_take  = s_axi_arvalid_in & s_axi_arready_out;
   wire [15:0] ctl_word = {unacked_request, 1'b0, vector_capture_select, 1'b0,
                           new_cpu_level, 1'b0, shown_vec};
   wire        rd_known = (rd_addr <= IPSR_IRQ_MASK_OFF) && (rd_addr[1:0] == 2'h0)
                          && (s_axi_araddr_in[31:5] == 27'h0);
   wire [15:0] rd_word  = (rd_addr == IPSR_CTRLSTAT_OFF) ? ctl_word :
                          (rd_addr == IPSR_IRQ_STAT_OFF) ? 16'(irq_stat) :
                          (rd_addr == IPSR_IRQ_MASK_OFF) ? 16'(irq_mask) :
                          (rd_addr[4] == 1'b0)           ? prio_reg[rd_addr[3:2]] : 16'h0000;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out  <= 1'b0;
         s_axi_rdata_out   <= 32'h00000000;
         s_axi_rresp_out   <= IPSR_RESP_OKAY;
      end else begin
         s_axi_arready_out <= ~s_axi_rvalid_out & ~rd_take;
         if (rd_take) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out  <= rd_known ? {16'h0000, rd_word} : 32'h00000000;
            s_axi_rresp_out  <= rd_known ? IPSR_RESP_OKAY : IPSR_RESP_SLVERR;
         end else if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // Checks
   // ==========================================================================
   disabled_src_quiet_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (src_live == '0) |=> !cpu_request_out)
      else $error("Request raised with no live source.");

   request_above_cpu_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      beats_cpu && !take_ack |=> cpu_request_out)
      else $error("Request above CPU level not forwarded.");

   request_cause_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cpu_request_out |-> $past(beats_cpu))
      else $error("Request raised without a live source above CPU level.");

   unacked_flag_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      held_off |=> ctl_word[IPSR_UNACKED_BIT])
      else $error("Held-off request not reported.");

   vector_live_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      vector_capture_select |-> ctl_word[6:0] == best_vector)
      else $error("Vector field does not follow the pending request.");

   vector_acked_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      take_ack ##1 !vector_capture_select |-> ctl_word[6:0] == $past(cpu_vector_code_out))
      else $error("Vector field does not hold the acknowledged vector.");

   level_update_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      take_ack |=> new_cpu_level == {1'b0, $past(fwd_prio)})
      else $error("New CPU level not captured on acknowledge.");

   reserved_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_axi_rvalid_out |-> s_axi_rdata_out[31:16] == 16'h0000)
      else $error("Upper read bits not zero.");

   prio_mask_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (prio_reg[3] & 16'hFF88) == 16'h0000)
      else $error("Unused bits of the fourth priority register set.");

   // ==========================================================================
   // Checks of the CPU side, status state and read path
   // ==========================================================================
   ack_drops_req_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      take_ack |=> !cpu_request_out)
      else $error("Request stands after acknowledge.");

   held_off_quiet_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      held_off |=> !cpu_request_out)
      else $error("Request forwarded below CPU level.");

   unacked_clear_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !held_off |=> !unacked_request)
      else $error("Unacked flag without a held request.");

   level_stable_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !take_ack |=> $stable(new_cpu_level))
      else $error("New level moved without acknowledge.");

   acked_stable_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !take_ack |=> $stable(acked_vector))
      else $error("Acked vector moved without acknowledge.");

   capsel_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ctl_hi |=> vector_capture_select == $past(wr_word[IPSR_CAPSEL_BIT]))
      else $error("Capture select not written.");

   ack_level_out_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      take_ack |=> cpu_new_level_out == {1'b0, $past(fwd_prio)})
      else $error("Level output not captured.");

   unmapped_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      rd_take && !rd_known |=> s_axi_rdata_out == 32'h00000000)
      else $error("Unmapped read data not zero.");

   forward_event_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      evt_set[0] |=> irq_stat[0])
      else $error("Forward event not recorded.");

   generate
      for (gi = 0; gi < IPSR_NSRC; gi++) begin : g_best
         best_wins_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
            src_live[gi] |-> src_prio[gi] <= best_prio)
            else $error("A live source outranks the chosen one.");
      end
   endgenerate

endmodule
`default_nettype wire

// >>> ipsr_cpu_model.sv
// Behavioural model of the CPU core that takes requests from the priority arbiter.
`timescale 1ns/1ps
`default_nettype none
module ipsr_cpu_model (
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       request_in,
   input  wire logic [3:0] level_set_in,
   input  wire logic [3:0] ack_delay_in,
   output logic [3:0]      cpu_level_out,
   output logic            cpu_ack_out
);
   logic [3:0] wait_cnt;

   // The bench sets the level that the running code would hold.
   assign cpu_level_out = level_set_in;

   // Acknowledge only a standing request, after a chosen number of idle cycles.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cpu_ack_out <= 1'b0;
         wait_cnt    <= 4'h0;
      end else if (request_in && !cpu_ack_out && wait_cnt == ack_delay_in) begin
         cpu_ack_out <= 1'b1;
         wait_cnt    <= 4'h0;
      end else if (request_in && !cpu_ack_out) begin
         wait_cnt    <= wait_cnt + 4'h1;
      end else begin
         cpu_ack_out <= 1'b0;
         wait_cnt    <= 4'h0;
      end
   end
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the priority registers, status register and request arbiter.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ipsr_pkg::*;
   logic                 clk = 1'b0;
   logic                 rst_n = 1'b0;
   logic [31:0]          awaddr = '0, wdata = '0, araddr = '0, rdata;
   logic                 awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic                 awready, wready, bvalid, arready, rvalid, ack, req, irq;
   logic [1:0]           bresp, rresp;
   logic [IPSR_NSRC-1:0] flag = '0;
   logic [IPSR_NSRC-1:0] en = '1;
   logic [6:0]           vcode [IPSR_NSRC];
   logic [6:0]           vec;
   logic [3:0]           level_set = 4'h0, ack_delay = 4'h0, cpu_level, new_level;
   logic [15:0]          shadow [4];
   int                   ro [IPSR_NSRC] = '{0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 2, 3, 3};
   int                   sh [IPSR_NSRC] = '{12, 8, 4, 12, 8, 4, 0, 12, 8, 4, 0, 4, 0};
   int                   n_mismatch = 0, checks_done = 0, cyc = 0;

   always #5 clk = ~clk;

   ipsr_top u_dut (.clk_in(clk), .rst_n_in(rst_n), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
      .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(1'b1),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
      .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(1'b1),
      .src_flag_in(flag), .src_enable_in(en), .src_vector_code_in(vcode), .cpu_level_in(cpu_level),
      .cpu_ack_in(ack), .cpu_request_out(req), .cpu_vector_code_out(vec), .cpu_new_level_out(new_level),
      .irq_out(irq));

   ipsr_cpu_model u_cpu (.clk_in(clk), .rst_n_in(rst_n), .request_in(req), .level_set_in(level_set),
      .ack_delay_in(ack_delay), .cpu_level_out(cpu_level), .cpu_ack_out(ack));

   task automatic final_report();
      if (n_mismatch == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         final_report();
      end
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   function automatic logic [31:0] exp_prio(input int i, input logic [31:0] d);
      return {16'h0, d[15:0] & IPSR_REG_MASK[i]};
   endfunction

   function automatic logic [31:0] exp_ctrl(input logic u, input logic c, input logic [3:0] l, input logic [6:0] v);
      return {16'h0, u, 1'b0, c, 1'b0, l, 1'b0, v};
   endfunction

   // Address and data are offered together; bready and rready stay high throughout.
   task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      awaddr <= {27'h0, a};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      r = 2'h3;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            break;
         end
      end
      if (n == 50) chk("write answer", 32'h1, 32'h0);
   endtask

   task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      araddr <= {27'h0, a};
      arvalid <= 1'b1;
      r = 2'h3;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
            break;
         end
      end
      if (n == 50) chk("read answer", 32'h1, 32'h0);
   endtask

   task automatic clear_prio();
      logic [1:0] r;
      for (int i = 0; i < 4; i++) begin
         shadow[i] = 16'h0;
         axi_wr(5'(i * 4), 32'h0, r);
      end
   endtask

   task automatic set_prio(input int k, input logic [2:0] p);
      logic [1:0] r;
      shadow[ro[k]][sh[k] +: 3] = p;
      axi_wr(5'(ro[k] * 4), {16'h0, shadow[ro[k]]}, r);
   endtask

   initial begin
      logic [31:0] d, rd;
      logic [1:0]  r;
      logic [2:0]  p, last_p;
      int          i, k, n, last_k;
      void'($urandom(32'hb05b));
      for (i = 0; i < IPSR_NSRC; i++) vcode[i] <= 7'($urandom);
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      for (i = 0; i < 5; i++) begin
         axi_rd(5'(i * 4), d, r);
         chk("reset value", (i < 4) ? exp_prio(i, 32'h4444) : 32'h0, d);
      end
      for (n = 0; n < 16; n++) begin
         i = n % 4;
         d = (n < 4) ? 32'hFFFF_FFFF : $urandom;
         axi_wr(5'(i * 4), d, r);
         chk("write resp", {30'h0, IPSR_RESP_OKAY}, {30'h0, r});
         axi_rd(5'(i * 4), rd, r);
         chk("priority readback", exp_prio(i, d), rd);
      end
      axi_wr(IPSR_CTRLSTAT_OFF, 32'hFFFF_FFFF, r);
      axi_rd(IPSR_CTRLSTAT_OFF, rd, r);
      chk("status writable bits", exp_ctrl(1'b0, 1'b1, 4'h0, 7'h00), rd);
      axi_wr(IPSR_CTRLSTAT_OFF, 32'h0, r);
      axi_rd(5'h1C, rd, r);
      chk("unmapped read resp", {30'h0, IPSR_RESP_SLVERR}, {30'h0, r});
      chk("unmapped read data", 32'h0, rd);
      axi_wr(5'h1C, 32'hFFFF_FFFF, r);
      chk("unmapped write resp", {30'h0, IPSR_RESP_SLVERR}, {30'h0, r});
      axi_wr(IPSR_IRQ_MASK_OFF, 32'h3, r);
      for (int t = 0; t < 8; t++) begin
         clear_prio();
         k = $urandom % IPSR_NSRC;
         p = 3'(1 + $urandom % 7);
         level_set <= 4'($urandom % p);
         ack_delay <= 4'($urandom % 10);
         set_prio(k, p);
         flag <= 13'(1) << k;
         for (n = 0; n < 20 && req !== 1'b1; n++) @(posedge clk);
         chk("request raised", 32'h1, {31'h0, req});
         chk("request vector", {25'h0, vcode[k]}, {25'h0, vec});
         for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clk);
         flag <= '0;
         repeat (2) @(posedge clk);
         chk("new level", {28'h0, 1'b0, p}, {28'h0, new_level});
         axi_rd(IPSR_CTRLSTAT_OFF, rd, r);
         chk("last acknowledged", exp_ctrl(1'b0, 1'b0, {1'b0, p}, vcode[k]), rd);
         last_p = p;
         last_k = k;
      end
      chk("irq raised", 32'h1, {31'h0, irq});
      axi_rd(IPSR_IRQ_STAT_OFF, rd, r);
      chk("event status", 32'h3, rd);
      axi_wr(IPSR_IRQ_MASK_OFF, 32'h0, r);
      repeat (2) @(posedge clk);
      chk("irq masked", 32'h0, {31'h0, irq});
      axi_wr(IPSR_IRQ_STAT_OFF, 32'h3, r);
      axi_rd(IPSR_IRQ_STAT_OFF, rd, r);
      chk("event cleared", 32'h0, rd);
      clear_prio();
      set_prio(2, 3'h3);
      set_prio(9, 3'h6);
      level_set <= 4'h7;
      flag <= 13'h0204;
      repeat (4) @(posedge clk);
      chk("request held off", 32'h0, {31'h0, req});
      axi_wr(IPSR_CTRLSTAT_OFF, 32'h2000, r);
      axi_rd(IPSR_CTRLSTAT_OFF, rd, r);
      chk("highest pending", exp_ctrl(1'b1, 1'b1, {1'b0, last_p}, vcode[9]), rd);
      en <= 13'h1DFF;
      axi_rd(IPSR_CTRLSTAT_OFF, rd, r);
      chk("enable gates source", exp_ctrl(1'b1, 1'b1, {1'b0, last_p}, vcode[2]), rd);
      en <= '1;
      axi_wr(IPSR_CTRLSTAT_OFF, 32'h0, r);
      axi_rd(IPSR_CTRLSTAT_OFF, rd, r);
      chk("unacked with hold", exp_ctrl(1'b1, 1'b0, {1'b0, last_p}, vcode[last_k]), rd);
      clear_prio();
      level_set <= 4'h0;
      flag <= '1;
      repeat (4) @(posedge clk);
      chk("disabled sources", 32'h0, {31'h0, req});
      axi_rd(IPSR_CTRLSTAT_OFF, rd, r);
      chk("no unacked", exp_ctrl(1'b0, 1'b0, {1'b0, last_p}, vcode[last_k]), rd);
      flag <= '0;
      final_report();
   end
endmodule
`default_nettype wire
